/* File: rtl/msg_cfg.svh */
// Constants for the monitor entry security gate.
// Assumes a 40 MHz bus clock and a single-wire serial monitor link.
`ifndef MSG_CFG_SVH
`define MSG_CFG_SVH

// ==========================================================================
// Clock and link timing
`define MSG_CLK_HZ 40000000
`define MSG_BAUD 9600
`define MSG_BRK_BITS 10
`define MSG_SYNC_WAIT 2'h3

// ==========================================================================
// Security code
`define MSG_CODE_LEN 8
`define MSG_CODE_LAST_IDX 3'h7
`define MSG_CODE_FIRST 16'hFFF6
`define MSG_CODE_LAST 16'hFFFD
`define MSG_ERASED 8'hFF

// ==========================================================================
// Flash ranges and read answers
`define MSG_FL2_LO 16'h4000
`define MSG_FL2_HI 16'h7FFF
`define MSG_FL1_LO 16'h8000
`define MSG_FL1_HI 16'hFDFF
`define MSG_VEC_LO 16'hFFCC
`define MSG_VEC_HI 16'hFFFF
`define MSG_INVALID_RD 8'hAD

// ==========================================================================
// Status byte in RAM
`define MSG_STATUS_ADDR 16'h0040
`define MSG_STATUS_BIT 6

// ==========================================================================
// Serial frame
`define MSG_RX_START 4'h0
`define MSG_RX_STOP 4'h9
`define MSG_FIFO_DEPTH 8

`endif

/* File: rtl/msg_pkg.sv */
// Types shared by the monitor entry security gate, its checks and its bench.
// Assumes msg_cfg.svh is included where constants are needed.
package msg_pkg;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic fetch;
    logic [15:0] addr;
  } msg_rd_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic illegal_rst;
  } msg_rd_rsp_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } msg_ram_wr_s;

  typedef logic [7:0] msg_byte_t;
  typedef msg_byte_t [7:0] msg_code_t;

  // ========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    MSG_ST_IDLE = 4'h1,
    MSG_ST_RECV = 4'h2,
    MSG_ST_BRK = 4'h4,
    MSG_ST_CMD = 4'h8
  } msg_state_e;

endpackage

/* File: rtl/msg_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset and a clock enable.
`timescale 1ns/100ps
module msg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // ========================================================================
  // Storage
  always_ff @(posedge clk_in)
  begin
    if (ce_in && push)
    begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // ========================================================================
  // Pointers and fill level
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce_in)
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

/* File: rtl/msg_gate.sv */
// Monitor entry security gate: receives the code bytes, compares, unlocks
// flash access, sends the break and reports the result to RAM.
// Assumes the flash presents the stored code bytes and answers reads itself.
`timescale 1ns/100ps
`include "msg_cfg.svh"
module msg_gate #(
  parameter int BIT_CYC = `MSG_CLK_HZ / `MSG_BAUD
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic por_n_in,
  input wire logic ce_in,
  input wire logic mon_entry_in,
  input wire logic monitor_serial_pin_in,
  output logic monitor_serial_pin_out,
  output logic monitor_serial_pin_oe_n_out,
  input wire msg_pkg::msg_code_t code_in,
  input wire logic mass_erase_in,
  output logic code_erase_out,
  input wire msg_pkg::msg_rd_req_s rd_req_in,
  input wire logic [7:0] flash_data_in,
  output msg_pkg::msg_rd_rsp_s rd_rsp_out,
  output msg_pkg::msg_ram_wr_s ram_wr_out,
  output logic unlocked_out,
  output logic monitor_mode_out,
  output logic cmd_valid_out,
  input wire logic cmd_ready_in,
  output logic [7:0] cmd_data_out,
  output logic overrun_out
);

  localparam logic [15:0] BIT_C = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_C = 16'(BIT_CYC / 2 - 1);
  localparam logic [19:0] BRK_C = 20'(BIT_CYC * `MSG_BRK_BITS - 1);

  msg_pkg::msg_state_e state_q;
  msg_pkg::msg_code_t code_q;
  logic unlock_q;
  logic pend_q;
  logic [1:0] wait_q;
  logic mon_s1_q, mon_s2_q;
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  logic rx_busy_q;
  logic [3:0] rx_bit_q;
  logic [15:0] rx_tmr_q;
  logic [7:0] rx_sh_q;
  logic rx_push_q;
  logic [2:0] idx_q;
  logic match_q;
  logic [19:0] brk_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic pop;
  logic last_pop;
  logic final_match;
  logic in_flash;

  assign pop = fifo_out_valid && fifo_out_ready;
  assign last_pop = pop && (state_q == msg_pkg::MSG_ST_RECV) && (idx_q == `MSG_CODE_LAST_IDX);
  // Byte n is held against location FFF6+n
  assign final_match = match_q && (fifo_out_data == code_q[idx_q]);
  assign fifo_out_ready = (state_q == msg_pkg::MSG_ST_RECV) ||
                          ((state_q == msg_pkg::MSG_ST_CMD) && (!cmd_valid_out || cmd_ready_in));
  assign in_flash = ((rd_req_in.addr >= `MSG_FL2_LO) && (rd_req_in.addr <= `MSG_FL2_HI)) ||
                    ((rd_req_in.addr >= `MSG_FL1_LO) && (rd_req_in.addr <= `MSG_FL1_HI)) ||
                    ((rd_req_in.addr >= `MSG_VEC_LO) && (rd_req_in.addr <= `MSG_VEC_HI));

  // ==========================================================================
  // Pin synchronisers
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      mon_s1_q <= 1'b0;
      mon_s2_q <= 1'b0;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end
    else if (ce_in)
    begin
      mon_s1_q <= mon_entry_in;
      mon_s2_q <= mon_s1_q;
      rx_s1_q <= monitor_serial_pin_in;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // ==========================================================================
  // Power-on state: survives every other reset
  always_ff @(posedge clk_in or negedge por_n_in)
  begin
    if (!por_n_in)
    begin
      unlock_q <= 1'b0;
      pend_q <= 1'b1;
    end
    else if (ce_in && last_pop)
    begin
      pend_q <= 1'b0;
      if (final_match)
      begin
        unlock_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= msg_pkg::MSG_ST_IDLE;
      wait_q <= 2'h0;
      idx_q <= 3'h0;
      match_q <= 1'b1;
      brk_q <= 20'h00000;
      monitor_mode_out <= 1'b0;
    end
    else if (ce_in)
    begin
      case (state_q)
        msg_pkg::MSG_ST_IDLE:
        begin
          // Strap is sampled every idle cycle after the synchroniser has settled, until it is seen high
          if (wait_q != `MSG_SYNC_WAIT)
          begin
            wait_q <= wait_q + 2'h1;
          end
          else if (!monitor_mode_out && mon_s2_q)
          begin
            monitor_mode_out <= 1'b1;
            idx_q <= 3'h0;
            match_q <= 1'b1;
            state_q <= pend_q ? msg_pkg::MSG_ST_RECV : msg_pkg::MSG_ST_CMD;
          end
        end
        msg_pkg::MSG_ST_RECV:
        begin
          if (pop)
          begin
            match_q <= final_match;
            idx_q <= idx_q + 3'h1;
            if (last_pop)
            begin
              brk_q <= BRK_C;
              state_q <= msg_pkg::MSG_ST_BRK;
            end
          end
        end
        msg_pkg::MSG_ST_BRK:
        begin
          if (brk_q == 20'h00000)
          begin
            state_q <= msg_pkg::MSG_ST_CMD;
          end
          else
          begin
            brk_q <= brk_q - 20'h00001;
          end
        end
        msg_pkg::MSG_ST_CMD:
        begin
          state_q <= msg_pkg::MSG_ST_CMD;
        end
        default:
        begin
          state_q <= msg_pkg::MSG_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Break transmitter: line driven low for the whole break, released after
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      monitor_serial_pin_out <= 1'b1;
      monitor_serial_pin_oe_n_out <= 1'b1;
    end
    else if (ce_in)
    begin
      monitor_serial_pin_out <= !(last_pop || ((state_q == msg_pkg::MSG_ST_BRK) && (brk_q != 20'h00000)));
      monitor_serial_pin_oe_n_out <= !(last_pop || ((state_q == msg_pkg::MSG_ST_BRK) && (brk_q != 20'h00000)));
    end
  end

  // ==========================================================================
  // Serial receiver, LSB first; idle during own break to avoid hearing it
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_busy_q <= 1'b0;
      rx_bit_q <= `MSG_RX_START;
      rx_tmr_q <= 16'h0000;
      rx_sh_q <= 8'h00;
      rx_push_q <= 1'b0;
    end
    else if (ce_in)
    begin
      rx_push_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (rx_s3_q && !rx_s2_q && (state_q == msg_pkg::MSG_ST_RECV || state_q == msg_pkg::MSG_ST_CMD))
        begin
          rx_busy_q <= 1'b1;
          rx_bit_q <= `MSG_RX_START;
          rx_tmr_q <= HALF_C;
        end
      end
      else if (rx_tmr_q != 16'h0000)
      begin
        rx_tmr_q <= rx_tmr_q - 16'h0001;
      end
      else if (rx_bit_q == `MSG_RX_START)
      begin
        rx_busy_q <= !rx_s2_q;
        rx_bit_q <= rx_bit_q + 4'h1;
        rx_tmr_q <= BIT_C;
      end
      else if (rx_bit_q == `MSG_RX_STOP)
      begin
        rx_busy_q <= 1'b0;
        rx_push_q <= rx_s2_q;
      end
      else
      begin
        rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        rx_bit_q <= rx_bit_q + 4'h1;
        rx_tmr_q <= BIT_C;
      end
    end
  end

  // ==========================================================================
  // Byte buffer between receiver and comparator or command stream
  msg_fifo #(
    .WIDTH(8),
    .DEPTH(`MSG_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .in_valid_in(rx_push_q),
    .in_ready_out(fifo_in_ready),
    .in_data_in(rx_sh_q),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // A serial line cannot be stalled; a byte that finds the buffer full is lost
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      overrun_out <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_data_out <= 8'h00;
    end
    else if (ce_in)
    begin
      if (rx_push_q && !fifo_in_ready)
      begin
        overrun_out <= 1'b1;
      end
      if (pop && (state_q == msg_pkg::MSG_ST_CMD))
      begin
        cmd_valid_out <= 1'b1;
        cmd_data_out <= fifo_out_data;
      end
      else if (cmd_ready_in)
      begin
        cmd_valid_out <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Stored code copy, one byte per location
  genvar gi;
  generate
    for (gi = 0; gi < `MSG_CODE_LEN; gi++)
    begin : g_code
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          code_q[gi] <= `MSG_ERASED;
        end
        else if (ce_in)
        begin
          if (mass_erase_in)
          begin
            code_q[gi] <= `MSG_ERASED;
          end
          else if (state_q == msg_pkg::MSG_ST_IDLE)
          begin
            code_q[gi] <= code_in[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Flash read gate, result report and erase request
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rd_rsp_out <= '0;
      ram_wr_out <= '0;
      code_erase_out <= 1'b0;
      unlocked_out <= 1'b0;
    end
    else if (ce_in)
    begin
      unlocked_out <= unlock_q;
      code_erase_out <= mass_erase_in;
      rd_rsp_out.valid <= rd_req_in.valid;
      rd_rsp_out.data <= flash_data_in;
      rd_rsp_out.illegal_rst <= 1'b0;
      if (rd_req_in.valid && in_flash && monitor_mode_out && !unlock_q)
      begin
        rd_rsp_out.data <= `MSG_INVALID_RD;
        rd_rsp_out.illegal_rst <= rd_req_in.fetch;
      end
      ram_wr_out.valid <= last_pop;
      ram_wr_out.addr <= `MSG_STATUS_ADDR;
      ram_wr_out.data <= 8'h00;
      ram_wr_out.data[`MSG_STATUS_BIT] <= final_match;
    end
  end

endmodule

/* File: testbench/msg_gate_props.sv */
// Concurrent checks on the ports of the monitor entry security gate.
// Assumes one clock domain; bound to every msg_gate instance below.
`timescale 1ns/100ps
module msg_gate_props #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic mass_erase_in,
  input wire logic code_erase_out,
  input wire msg_pkg::msg_rd_req_s rd_req_in,
  input wire logic [7:0] flash_data_in,
  input wire msg_pkg::msg_rd_rsp_s rd_rsp_out,
  input wire msg_pkg::msg_ram_wr_s ram_wr_out,
  input wire logic unlocked_out,
  input wire logic monitor_mode_out,
  input wire logic monitor_serial_pin_out,
  input wire logic monitor_serial_pin_oe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================================
  // Helpers
  logic [15:0] brk_cnt_q;
  logic gated;
  assign gated = rd_req_in.valid && ce_in && monitor_mode_out && !unlocked_out &&
    ((rd_req_in.addr >= 16'h4000 && rd_req_in.addr <= 16'hFDFF) || rd_req_in.addr >= 16'hFFCC);
  // Counts low drive cycles so the break length can be judged when it ends
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      brk_cnt_q <= 16'h0000;
    end
    else if (ce_in)
    begin
      brk_cnt_q <= monitor_serial_pin_oe_n_out ? 16'h0000 : brk_cnt_q + 16'h0001;
    end
  end
  // ==========================================================================
  // Properties
  sequence s_code_done;
    ram_wr_out.valid;
  endsequence
  sequence s_brk_start;
    $fell(monitor_serial_pin_oe_n_out);
  endsequence
  property p_brk_after_code;
    s_brk_start |-> ram_wr_out.valid || $past(ram_wr_out.valid) || $past(ram_wr_out.valid, 2);
  endproperty
  a_brk_after_code: assert property (p_brk_after_code) else $error("break without code entry");
  property p_code_brk;
    s_code_done |-> ##[0:2] !monitor_serial_pin_oe_n_out;
  endproperty
  a_code_brk: assert property (p_code_brk) else $error("no break after code");
  property p_brk_low;
    !monitor_serial_pin_oe_n_out |-> !monitor_serial_pin_out;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break not low");
  property p_brk_len;
    $rose(monitor_serial_pin_oe_n_out) |-> brk_cnt_q >= 10 * BIT_CYC - 1 && brk_cnt_q <= 10 * BIT_CYC + 1;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");
  property p_status_unlock;
    s_code_done ##0 (ram_wr_out.data[6] && ram_wr_out.addr == 16'h0040) |-> ##[0:2] unlocked_out;
  endproperty
  a_status_unlock: assert property (p_status_unlock) else $error("status set without unlock");
  property p_status_lock;
    s_code_done ##0 !ram_wr_out.data[6] |=> (!unlocked_out)[*3];
  endproperty
  a_status_lock: assert property (p_status_lock) else $error("unlocked after mismatch");
  property p_stay;
    unlocked_out |=> unlocked_out;
  endproperty
  a_stay: assert property (p_stay) else $error("unlock lost");
  property p_locked_rd;
    gated |=> unlocked_out || rd_rsp_out.data == 8'hAD;
  endproperty
  a_locked_rd: assert property (p_locked_rd) else $error("locked read leaked data");
  property p_locked_fetch;
    gated && rd_req_in.fetch |=> unlocked_out || rd_rsp_out.illegal_rst;
  endproperty
  a_locked_fetch: assert property (p_locked_fetch) else $error("locked fetch not reset");
  property p_open_rd;
    rd_req_in.valid && ce_in && unlocked_out |=>
      rd_rsp_out.valid && rd_rsp_out.data == $past(flash_data_in) && !rd_rsp_out.illegal_rst;
  endproperty
  a_open_rd: assert property (p_open_rd) else $error("unlocked read wrong");
  property p_erase;
    mass_erase_in && ce_in |=> code_erase_out;
  endproperty
  a_erase: assert property (p_erase) else $error("no code erase");
endmodule

bind msg_gate msg_gate_props #(.BIT_CYC(BIT_CYC)) props_u (
  .clk_in(clk_in),
  .resetn_in(resetn_in),
  .ce_in(ce_in),
  .mass_erase_in(mass_erase_in),
  .code_erase_out(code_erase_out),
  .rd_req_in(rd_req_in),
  .flash_data_in(flash_data_in),
  .rd_rsp_out(rd_rsp_out),
  .ram_wr_out(ram_wr_out),
  .unlocked_out(unlocked_out),
  .monitor_mode_out(monitor_mode_out),
  .monitor_serial_pin_out(monitor_serial_pin_out),
  .monitor_serial_pin_oe_n_out(monitor_serial_pin_oe_n_out)
);

/* File: testbench/msg_host.sv */
// Host model: sends 8N1 frames, LSB first, on the monitor line.
// Assumes the line is pulled high whenever the host is not sending.
`timescale 1ns/100ps
module msg_host #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // Gap gives a slow host; zero sends frames back to back
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk_in);
      line_out <= frame[i];
      repeat (BIT_CYC - 1) @(posedge clk_in);
    end
    repeat (gap) @(posedge clk_in);
  endtask
endmodule

/* File: testbench/msg_gate_bench.sv */
// Self-checking bench for the monitor entry security gate.
// Assumes msg_host on the serial line and a shortened bit time.
`timescale 1ns/100ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("FAIL %0t %s", $time, m); end end
`define AWAIT(c, n) begin wait_n = 0; while (!(c) && wait_n < (n)) begin @(posedge clk_in); #1; wait_n++; end `CHK((c), 1'b1, "wait ran out") end
module msg_gate_bench;
  localparam int BC = 16;
  typedef struct packed {
    logic fetch;
    logic [15:0] addr;
    logic [7:0] fd;
    logic [7:0] exp;
    logic ill;
  } msg_row_s;
  // Code locations hold user values, never blank
  localparam msg_pkg::msg_code_t CODE = {8'h3C, 8'hA5, 8'h71, 8'h0E, 8'hC3, 8'h5A, 8'h96, 8'h2B};
  msg_row_s rows [9] = '{{1'b0, 16'h4000, 8'h11, 8'hAD, 1'b0}, {1'b1, 16'h7FFF, 8'h22, 8'hAD, 1'b1},
    {1'b0, 16'h8000, 8'h33, 8'hAD, 1'b0}, {1'b1, 16'hFDFF, 8'h44, 8'hAD, 1'b1},
    {1'b0, 16'hFFCC, 8'h55, 8'hAD, 1'b0}, {1'b1, 16'hFFF6, 8'h66, 8'hAD, 1'b1},
    {1'b0, 16'h3FFF, 8'h77, 8'h77, 1'b0}, {1'b1, 16'hFE00, 8'h88, 8'h88, 1'b0},
    {1'b0, 16'h0040, 8'h99, 8'h99, 1'b0}};
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic por_n_in = 1'b0;
  logic mass_erase_in = 1'b0;
  logic cmd_ready_in = 1'b0;
  logic ram_seen = 1'b0;
  logic [7:0] flash_data_in = 8'h00;
  logic host_line, code_erase_out, pin_out, oe_n, unlocked_out, monitor_mode_out, cmd_valid_out, overrun_out;
  logic [7:0] cmd_data_out;
  msg_pkg::msg_rd_req_s rd_req_in = '0;
  msg_pkg::msg_rd_rsp_s rd_rsp_out;
  msg_pkg::msg_ram_wr_s ram_wr_out, ram_last;
  msg_pkg::msg_code_t bad;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int brk_len = 0;
  int wait_n;
  wire mon_line = host_line & (oe_n | pin_out);
  msg_gate #(.BIT_CYC(BC)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .por_n_in(por_n_in), .ce_in(1'b1),
    .mon_entry_in(1'b1), .monitor_serial_pin_in(mon_line), .monitor_serial_pin_out(pin_out),
    .monitor_serial_pin_oe_n_out(oe_n), .code_in(CODE), .mass_erase_in(mass_erase_in),
    .code_erase_out(code_erase_out), .rd_req_in(rd_req_in), .flash_data_in(flash_data_in),
    .rd_rsp_out(rd_rsp_out), .ram_wr_out(ram_wr_out), .unlocked_out(unlocked_out),
    .monitor_mode_out(monitor_mode_out), .cmd_valid_out(cmd_valid_out), .cmd_ready_in(cmd_ready_in),
    .cmd_data_out(cmd_data_out), .overrun_out(overrun_out));
  msg_host #(.BIT_CYC(BC)) host_u (.clk_in(clk_in), .line_out(host_line));
  initial forever #12.5 clk_in = ~clk_in;
  // ==========================================================================
  // Watchers
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (ram_wr_out.valid)
      ram_last <= ram_wr_out;
    if (ram_wr_out.valid)
      ram_seen <= 1'b1;
    if (!oe_n)
      brk_len <= brk_len + 1;
    if (cyc == 12000)
    begin
      fail_count++;
      conclude();
    end
  end
  // ==========================================================================
  // Tasks
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic por);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    por_n_in <= ~por;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    por_n_in <= 1'b1;
    ram_seen <= 1'b0;
    brk_len <= 0;
    `AWAIT(monitor_mode_out, 40)
  endtask
  // Break and status must be absent before the eighth byte and are judged once all eight are in
  task automatic send_code(input msg_pkg::msg_code_t c);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
        `CHK({oe_n, ram_seen}, 2'h2, "break or status too early")
      host_u.send_byte(c[i], 0);
    end
    `AWAIT(ram_seen, 40)
    `AWAIT(brk_len > 0 && oe_n, 200)
    `CHK(brk_len >= 10 * BC - 1 && brk_len <= 10 * BC + 1, 1'b1, "break length")
    `CHK(ram_last.addr, 16'h0040, "status address")
  endtask
  task automatic rd(input msg_row_s r);
    @(posedge clk_in);
    rd_req_in <= '{1'b1, r.fetch, r.addr};
    flash_data_in <= r.fd;
    @(posedge clk_in);
    rd_req_in <= '0;
    #1;
    `CHK(rd_rsp_out, {1'b1, r.exp, r.ill}, "read answer")
  endtask
  // ==========================================================================
  // Main sequence
  initial
  begin
    do_reset(1'b1);
    bad = CODE;
    bad[7][0] = ~bad[7][0];
    send_code(bad);
    `CHK({ram_last.data[6], unlocked_out, monitor_mode_out}, 3'h1, "failed entry state")
    foreach (rows[i])
      rd(rows[i]);
    for (int i = 0; i < 10; i++)
      host_u.send_byte(8'h10 + i[7:0], i * 3);
    `CHK(overrun_out, 1'b1, "overrun")
    for (int i = 0; i < 8; i++)
    begin
      `AWAIT(cmd_valid_out, 20)
      `CHK(cmd_data_out, 8'h10 + i[7:0], "command byte order")
      @(posedge clk_in);
      cmd_ready_in <= 1'b1;
      @(posedge clk_in);
      cmd_ready_in <= 1'b0;
      #1;
    end
    @(posedge clk_in);
    cmd_ready_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    cmd_ready_in <= 1'b0;
    #1;
    `CHK(cmd_valid_out, 1'b0, "buffer not empty")
    // A new attempt needs a fresh power-on
    do_reset(1'b1);
    send_code(CODE);
    `CHK({ram_last.data[6], unlocked_out}, 2'h3, "passed entry state")
    rd('{1'b1, 16'hFFF6, 8'hE7, 8'hE7, 1'b0});
    do_reset(1'b0);
    repeat (40) @(posedge clk_in);
    #1;
    `CHK({unlocked_out, ram_seen, brk_len == 0}, 3'h5, "warm reset state")
    rd('{1'b0, 16'h8000, 8'h3E, 8'h3E, 1'b0});
    @(posedge clk_in);
    mass_erase_in <= 1'b1;
    @(posedge clk_in);
    mass_erase_in <= 1'b0;
    #1;
    `CHK(code_erase_out, 1'b1, "code erase request")
    conclude();
  end
endmodule
